// ### design/motor_pwm_consts.svh
`ifndef MOTOR_PWM_CONSTS_SVH
`define MOTOR_PWM_CONSTS_SVH

// Register byte offsets (one aligned 32-bit word each)
`define OFS_CTRL        8'h00
`define OFS_COUNT       8'h04
`define OFS_PERIOD      8'h08
`define OFS_ACT_PERIOD  8'h0c
`define OFS_DUTY0       8'h10
`define OFS_DUTY1       8'h14
`define OFS_DUTY2       8'h18

// Control register field positions
`define CTRL_MODE_LSB   0
`define CTRL_PRESC_LSB  2
`define CTRL_POST_LSB   4
`define CTRL_RUN_BIT    15

// Count register direction flag position
`define COUNT_DIR_BIT   15

// Prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
`define PRESC_LIM_1     6'h00
`define PRESC_LIM_4     6'h03
`define PRESC_LIM_16    6'h0f
`define PRESC_LIM_64    6'h3f

// Bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### design/motor_pwm_pkg.sv
package motor_pwm_pkg;

  // Counting modes in field order 00, 01, 10, 11
  typedef enum logic [1:0] {
    MODE_FREE,
    MODE_SINGLE,
    MODE_UPDN,
    MODE_DOUBLE
  } tb_mode_t;

  // Master-driven AXI4-Lite signals
  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  // Slave-driven AXI4-Lite signals
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  // Whole state of the time base block
  typedef struct packed {
    logic             run;        // time_base_run
    tb_mode_t         mode;       // time_base_mode_sel
    logic [1:0]       presc_sel;  // prescale_sel
    logic [3:0]       post_sel;   // postscale_sel
    logic [14:0]      count;      // time_base_count
    logic             dir;        // count_direction_flag
    logic [14:0]      per_buf;    // period_value, software side
    logic [14:0]      per_act;    // period_value, compare side
    logic [2:0][15:0] duty;       // Duty values per pair
    logic [5:0]       presc_cnt;
    logic [3:0]       post_cnt;
    logic [2:0]       high;
    logic [2:0]       low;
    logic             event_p;
    logic             aw_have;
    logic [31:0]      awaddr;
    logic             w_have;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    axi_rsp_t         bus;
  } tb_state_t;

endpackage : motor_pwm_pkg

// ### design/motor_pwm_time_base_edge.sv
// Behaviour
// - 15-bit count, bit 15 reads direction
// - Run bit starts/stops; stop keeps count
// - Period match: wrap or reverse next tick
// - Zero period: stopped, no events, no update
// - Mode field selects four counting modes
// - Free running wraps, postscaled match event
// - Single shot: wrap, clear run, one event
// - Up/down reverses; postscaled event at zero
// - Double update: events at zero and match
// - Prescale 1, 4, 16 or 64
// - Prescaler cleared by count/control write
// - 4-bit postscaler, ratios one to sixteen
// - Postscaler cleared by count/control write
// - Period buffer loads at wrap or zero
// - Disabled time base copies period buffer
// - Edge outputs: on at zero, off at duty
// - Duty zero off; above period on
// - Three pairs; low is inverse of high

`include "motor_pwm_consts.svh"

module motor_pwm_time_base_edge
  import motor_pwm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire axi_req_t   axi_in,
  output axi_rsp_t        axi_out,
  output logic [2:0]      pair_high_output,
  output logic [2:0]      pair_low_output,
  output logic            tb_event
);

  tb_state_t   s_r;        // Registered state
  tb_state_t   s_nxt;      // Next state
  logic        tick;       // Counter clock after prescaler
  logic        match;      // Count equals active period
  logic        do_wr;      // Write address and data both held
  logic [7:0]  wr_ofs;     // Offset of the pending write
  logic [5:0]  presc_lim;  // Terminal count of the prescaler

  // Prescaler terminal count from the select field
  always_comb begin
    case (s_r.presc_sel)
      2'h0:    presc_lim = `PRESC_LIM_1;
      2'h1:    presc_lim = `PRESC_LIM_4;
      2'h2:    presc_lim = `PRESC_LIM_16;
      default: presc_lim = `PRESC_LIM_64;
    endcase
  end

  // A zero period holds the prescaler, so no tick ever comes
  assign tick  = s_r.run && (s_r.per_act != 15'h0000)
                 && (s_r.presc_cnt == presc_lim);
  assign match = (s_r.count == s_r.per_act);
  assign do_wr = s_r.aw_have && s_r.w_have && !s_r.bus.bvalid;
  assign wr_ofs = s_r.awaddr[7:0];

  // Register read view; hit is low for unmapped offsets
  function automatic logic [32:0] reg_read(input tb_state_t s,
                                           input logic [7:0] ofs);
    logic [32:0] r;
    r = 33'h0;
    if (ofs[1:0] == 2'h0) begin
      case (ofs)
        `OFS_CTRL: begin
          r[32] = 1'b1;
          r[`CTRL_RUN_BIT] = s.run;
          r[`CTRL_MODE_LSB +: 2] = s.mode;
          r[`CTRL_PRESC_LSB +: 2] = s.presc_sel;
          r[`CTRL_POST_LSB +: 4] = s.post_sel;
        end
        `OFS_COUNT: begin
          r[32] = 1'b1;
          r[14:0] = s.count;
          r[`COUNT_DIR_BIT] = s.dir;
        end
        `OFS_PERIOD: begin
          r[32] = 1'b1;
          r[14:0] = s.per_buf;
        end
        `OFS_ACT_PERIOD: begin
          r[32] = 1'b1;
          r[14:0] = s.per_act;
        end
        `OFS_DUTY0: begin
          r[32] = 1'b1;
          r[15:0] = s.duty[0];
        end
        `OFS_DUTY1: begin
          r[32] = 1'b1;
          r[15:0] = s.duty[1];
        end
        `OFS_DUTY2: begin
          r[32] = 1'b1;
          r[15:0] = s.duty[2];
        end
        default: r = 33'h0;
      endcase
    end
    return r;
  endfunction : reg_read

  // Next-state logic: time base, outputs and bus slave
  always_comb begin
    logic [32:0] rd;
    logic [31:0] wv;
    logic        post_ev;
    logic        ev;
    logic        edge_mode;
    logic        h;
    rd = 33'h0;
    wv = 32'h0;
    post_ev = 1'b0;
    ev = 1'b0;
    edge_mode = 1'b0;
    h = 1'b0;
    s_nxt = s_r;
    s_nxt.event_p = 1'b0;

    // While stopped the compare side follows the buffer
    if (!s_r.run) begin
      s_nxt.per_act = s_r.per_buf;
    end

    // Prescaler runs only while enabled with a live period
    if (s_r.run && s_r.per_act != 15'h0000) begin
      if (tick) begin
        s_nxt.presc_cnt = 6'h00;
      end else begin
        s_nxt.presc_cnt = s_r.presc_cnt + 6'h01;
      end
    end

    // Counter advance on each tick, per mode
    if (tick) begin
      case (s_r.mode)
        MODE_FREE, MODE_SINGLE: begin
          // Edge modes only count up; clear a flag left by up/down
          s_nxt.dir = 1'b0;
          if (match) begin
            s_nxt.count = 15'h0000;
            s_nxt.per_act = s_r.per_buf;
            if (s_r.mode == MODE_SINGLE) begin
              s_nxt.run = 1'b0;
              ev = 1'b1;
            end else begin
              post_ev = 1'b1;
            end
          end else begin
            s_nxt.count = s_r.count + 15'h0001;
          end
        end
        MODE_UPDN, MODE_DOUBLE: begin
          if (!s_r.dir) begin
            if (match) begin
              // Turn downward on this tick
              s_nxt.dir = 1'b1;
              s_nxt.count = s_r.count - 15'h0001;
              ev = (s_r.mode == MODE_DOUBLE);
            end else begin
              s_nxt.count = s_r.count + 15'h0001;
            end
          end else if (s_r.count == 15'h0000) begin
            // Bottom of the triangle: reload and turn upward
            s_nxt.dir = 1'b0;
            s_nxt.count = 15'h0001;
            s_nxt.per_act = s_r.per_buf;
            if (s_r.mode == MODE_DOUBLE) begin
              ev = 1'b1;
            end else begin
              post_ev = 1'b1;
            end
          end else begin
            s_nxt.count = s_r.count - 15'h0001;
          end
        end
        default: s_nxt.count = s_r.count;
      endcase
    end

    // Postscaler thins free-running and up/down events
    if (post_ev) begin
      if (s_r.post_cnt == s_r.post_sel) begin
        s_nxt.post_cnt = 4'h0;
        ev = 1'b1;
      end else begin
        s_nxt.post_cnt = s_r.post_cnt + 4'h1;
      end
    end
    s_nxt.event_p = ev;

    // Write address and data channels, taken in either order
    if (axi_in.awvalid && s_r.bus.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = axi_in.awaddr;
    end
    if (axi_in.wvalid && s_r.bus.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = axi_in.wdata;
      s_nxt.wstrb = axi_in.wstrb;
    end
    if (s_r.bus.bvalid && axi_in.bready) begin
      s_nxt.bus.bvalid = 1'b0;
    end

    // Register write; software beats hardware in the same cycle
    if (do_wr) begin
      rd = reg_read(s_r, wr_ofs);
      for (int b = 0; b < 4; b++) begin
        wv[b*8 +: 8] = s_r.wstrb[b] ? s_r.wdata[b*8 +: 8]
                                    : rd[b*8 +: 8];
      end
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bus.bvalid = 1'b1;
      s_nxt.bus.bresp = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
      case (wr_ofs)
        `OFS_CTRL: begin
          // Clearing run leaves the count where it stands
          s_nxt.run = wv[`CTRL_RUN_BIT];
          s_nxt.mode = tb_mode_t'(wv[`CTRL_MODE_LSB +: 2]);
          s_nxt.presc_sel = wv[`CTRL_PRESC_LSB +: 2];
          s_nxt.post_sel = wv[`CTRL_POST_LSB +: 4];
          s_nxt.presc_cnt = 6'h00;
          s_nxt.post_cnt = 4'h0;
        end
        `OFS_COUNT: begin
          s_nxt.count = wv[14:0];
          s_nxt.presc_cnt = 6'h00;
          s_nxt.post_cnt = 4'h0;
        end
        `OFS_PERIOD: s_nxt.per_buf = wv[14:0];
        `OFS_DUTY0:  s_nxt.duty[0] = wv[15:0];
        `OFS_DUTY1:  s_nxt.duty[1] = wv[15:0];
        `OFS_DUTY2:  s_nxt.duty[2] = wv[15:0];
        default: ;   // Read-only or unmapped: ignored
      endcase
    end

    // Read channel: answer one cycle after the address is taken
    if (s_r.bus.rvalid && axi_in.rready) begin
      s_nxt.bus.rvalid = 1'b0;
    end
    if (axi_in.arvalid && s_r.bus.arready) begin
      rd = reg_read(s_r, axi_in.araddr[7:0]);
      s_nxt.bus.rvalid = 1'b1;
      s_nxt.bus.rdata = rd[31:0];
      s_nxt.bus.rresp = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
    end
    s_nxt.bus.awready = !s_nxt.aw_have;
    s_nxt.bus.wready = !s_nxt.w_have;
    // One read at a time, so stall until the answer is taken
    s_nxt.bus.arready = !s_nxt.bus.rvalid;

    // Edge-aligned duty compare per pair
    edge_mode = (s_nxt.mode == MODE_FREE) || (s_nxt.mode == MODE_SINGLE);
    for (int i = 0; i < 3; i++) begin
      if (!edge_mode || (s_nxt.mode == MODE_SINGLE && !s_nxt.run)) begin
        // Center-aligned is not built; a spent shot stays off
        h = 1'b0;
      end else if (s_nxt.duty[i] == 16'h0000
                   || s_nxt.duty[i] == {1'b0, s_nxt.count}) begin
        h = 1'b0;
      end else if (s_nxt.count == 15'h0000) begin
        h = 1'b1;
      end else begin
        h = s_r.high[i];
      end
      s_nxt.high[i] = h;
      s_nxt.low[i] = ~h;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.low <= 3'h7;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign axi_out          = s_r.bus;
  assign pair_high_output = s_r.high;
  assign pair_low_output  = s_r.low;
  assign tb_event         = s_r.event_p;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Stopped time base keeps its count unless software writes it
  a_count_hold_stop: assert property (
    !s_r.run && !(do_wr && wr_ofs == `OFS_COUNT)
    |=> s_r.count == $past(s_r.count))
    else $error("count moved while stopped");

  // A zero period must never let an event through
  a_zero_period_idle: assert property (
    s_r.run && s_r.per_act == 15'h0000
    |=> !s_r.event_p)
    else $error("event with zero period");

  // Free running wraps to zero and counts upward again
  a_free_wrap: assert property (
    tick && match && s_r.mode == MODE_FREE && !do_wr
    |=> s_r.count == 15'h0000 && !s_r.dir)
    else $error("free mode did not wrap");

  // Single shot halts itself and gives exactly one pulse
  a_single_done: assert property (
    tick && match && s_r.mode == MODE_SINGLE && !do_wr
    |=> !s_r.run && s_r.event_p ##1 !s_r.event_p)
    else $error("single shot did not finish");

  // Up/down turns at the period without repeating the top count
  a_updn_reverse: assert property (
    tick && match && !s_r.dir && s_r.mode == MODE_UPDN && !do_wr
    |=> s_r.dir && s_r.count == $past(s_r.count) - 15'h0001)
    else $error("up/down did not reverse");

  // Double update fires at both ends of the triangle
  a_double_events: assert property (
    tick && s_r.mode == MODE_DOUBLE
    && ((match && !s_r.dir) || (s_r.dir && s_r.count == 15'h0000))
    |=> s_r.event_p)
    else $error("double update event missing");

  // Either register write restarts both scalers
  a_scaler_clear: assert property (
    do_wr && (wr_ofs == `OFS_CTRL || wr_ofs == `OFS_COUNT)
    |=> s_r.presc_cnt == 6'h00 && s_r.post_cnt == 4'h0)
    else $error("scalers not cleared by write");

  // Stopped, the compare side tracks the software period
  a_buffer_copy: assert property (
    !s_r.run |=> s_r.per_act == $past(s_r.per_buf))
    else $error("period buffer not copied");

  // A duty of zero on pair 0 never lets its high side on
  a_duty_zero_off: assert property (
    s_r.duty[0] == 16'h0000 && $past(s_r.duty[0]) == 16'h0000
    |-> !s_r.high[0])
    else $error("zero duty drove output");

  // Complement holds at all times, reset included
  a_pair_inverse: assert property (
    s_r.low == ~s_r.high)
    else $error("low output not inverse of high");

  // Edge-aligned modes only count upward, so the flag reads up
  a_dir_up_edge: assert property (
    tick && (s_r.mode == MODE_FREE || s_r.mode == MODE_SINGLE)
    |=> !s_r.dir)
    else $error("direction flag set in edge mode");

  // Pulses last one clock; a period of one is left out, since
  // there two events may fall on neighbouring ticks
  a_event_pulse: assert property (
    s_r.event_p && s_r.per_act != 15'h0001
    |=> !s_r.event_p)
    else $error("event pulse longer than one clock");

  c_free_event: cover property (
    s_r.mode == MODE_FREE && s_r.event_p);
  c_single_done: cover property (
    s_r.mode == MODE_SINGLE && $fell(s_r.run));
  c_updn_turn: cover property (
    s_r.mode == MODE_UPDN && $fell(s_r.dir));
  c_double_event: cover property (
    s_r.mode == MODE_DOUBLE && s_r.event_p);
  c_post_thinned: cover property (
    s_r.mode == MODE_FREE && s_r.post_sel != 4'h0 && s_r.event_p);

endmodule : motor_pwm_time_base_edge

// ### test/gate_driver_model.sv
// Power stage seen from the block: three half bridges, one per pair
module gate_driver_model
  import motor_pwm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [2:0] pair_high_output,
  input  wire logic [2:0] pair_low_output,
  output logic      [7:0] fault_count
);
  timeunit 1ns;
  timeprecision 1ns;

  // Both switches of a leg on shorts the supply; both off lets it float
  always @(posedge ref_clk) begin
    if (rst) begin
      fault_count <= 8'h00;
    end else if ((pair_high_output ^ pair_low_output) !== 3'h7) begin
      fault_count <= fault_count + 8'h01;
    end
  end
endmodule : gate_driver_model

// ### test/motor_pwm_time_base_edge_tb.sv
`include "motor_pwm_consts.svh"

module motor_pwm_time_base_edge_tb
  import motor_pwm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  // One time base setup and the event spacing it must give, in clocks
  typedef struct {
    logic [1:0]  mode;
    logic [1:0]  presc;
    logic [3:0]  post;
    logic [14:0] per;
    int          gap;
  } row_t;

  logic        ref_clk;
  logic        rst;
  axi_req_t    req;
  axi_rsp_t    rsp;
  logic [2:0]  hi;
  logic [2:0]  lo;
  logic        tb_event;
  logic [7:0]  faults;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [31:0] c;
  logic        d0;
  int          bad_count = 0;
  int          tests_run = 0;
  int          ev_cnt    = 0;
  logic        ev_prev   = 1'b0;
  int          gap, h0, h1, h2, e0;

  row_t rows [9] = '{
    '{2'h0, 2'h0, 4'h0, 15'h0004, 5},
    '{2'h0, 2'h1, 4'h0, 15'h0004, 20},
    '{2'h0, 2'h2, 4'h0, 15'h0002, 48},
    '{2'h0, 2'h3, 4'h0, 15'h0001, 128},
    '{2'h0, 2'h0, 4'h2, 15'h0004, 15},
    '{2'h0, 2'h0, 4'hf, 15'h0001, 32},
    '{2'h2, 2'h0, 4'h0, 15'h0003, 6},
    '{2'h2, 2'h0, 4'h1, 15'h0003, 12},
    '{2'h3, 2'h0, 4'h5, 15'h0003, 3}
  };

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  motor_pwm_time_base_edge u_motor_pwm_time_base_edge (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .axi_in           (req),
    .axi_out          (rsp),
    .pair_high_output (hi),
    .pair_low_output  (lo),
    .tb_event         (tb_event)
  );

  gate_driver_model u_gate_driver_model (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .pair_high_output (hi),
    .pair_low_output  (lo),
    .fault_count      (faults)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Address and data go out together; each drops once its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    @(posedge ref_clk);
    req.awaddr  <= {24'h000000, a};
    req.awvalid <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    while (!b) begin
      @(posedge ref_clk);
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
      if (rsp.bvalid === 1'b1) begin
        b = 1'b1;
        rs = rsp.bresp;
        req.bready <= 1'b0;
      end
    end
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    logic ar;
    ar = 1'b1;
    @(posedge ref_clk);
    req.araddr  <= {24'h000000, a};
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (ar && rsp.arready === 1'b1) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rdr

  // Stopping first lets the new period reach the compare side at once
  task automatic setup(input logic [1:0] m, input logic [1:0] p,
                       input logic [3:0] q, input logic [14:0] per);
    wr(`OFS_CTRL, 32'h0);
    // Start from zero so an old count never lies above the new period
    wr(`OFS_COUNT, 32'h0);
    wr(`OFS_PERIOD, {17'h0, per});
    wr(`OFS_CTRL, {16'h0, 1'b1, 7'h0, q, p, m});
  endtask : setup

  // Clocks between two events
  task automatic space();
    @(posedge ref_clk iff tb_event === 1'b1);
    gap = 0;
    do begin
      @(posedge ref_clk);
      gap++;
    end while (tb_event !== 1'b1);
  endtask : space

  // Counts events; a pulse held two clocks is flagged
  always @(posedge ref_clk) begin
    ev_prev <= tb_event;
    if (tb_event === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
    end
    if (tb_event === 1'b1 && ev_prev === 1'b1) begin
      check(32'h2, 32'h1);
    end
  end

  // Long enough for every setup, including the slowest prescale row
  initial begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    req = '0;
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check({29'h0, lo}, {29'h0, ~hi});
    rdr(`OFS_CTRL);
    check(rd, 32'h0);
    // Zero period: running yet frozen, and the buffer does not pass
    wr(`OFS_CTRL, 32'h8000);
    e0 = ev_cnt;
    repeat (100) @(posedge ref_clk);
    check(32'(ev_cnt - e0), 32'h0);
    rdr(`OFS_COUNT);
    check(rd, 32'h0);
    wr(`OFS_PERIOD, 32'hffff0005);
    rdr(`OFS_ACT_PERIOD);
    check(rd, 32'h0);
    wr(`OFS_CTRL, 32'h0);
    rdr(`OFS_ACT_PERIOD);
    check(rd, 32'h5);
    rdr(`OFS_PERIOD);
    check(rd, 32'h5);
    wr(`OFS_ACT_PERIOD, 32'h9);
    check({30'h0, rs}, {30'h0, `RESP_OKAY});
    wr(8'h1c, 32'h1);
    check({30'h0, rs}, {30'h0, `RESP_SLVERR});
    rdr(8'h1c);
    check(rd, 32'h0);
    check({30'h0, rs}, {30'h0, `RESP_SLVERR});
    foreach (rows[i]) begin
      setup(rows[i].mode, rows[i].presc, rows[i].post, rows[i].per);
      space();
      space();
      check(32'(gap), 32'(rows[i].gap));
    end
    // Single shot: one event whatever the postscaler, then halted
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_PERIOD, 32'h3);
    e0 = ev_cnt;
    wr(`OFS_CTRL, 32'h8031);
    repeat (40) @(posedge ref_clk);
    check(32'(ev_cnt - e0), 32'h1);
    rdr(`OFS_CTRL);
    check(rd, 32'h31);
    rdr(`OFS_COUNT);
    check(rd, 32'h0);
    // Edge outputs over ten whole periods of five clocks
    wr(`OFS_DUTY0, 32'h2);
    wr(`OFS_DUTY1, 32'h0);
    wr(`OFS_DUTY2, 32'h7);
    setup(2'h0, 2'h0, 4'h0, 15'h4);
    repeat (20) @(posedge ref_clk);
    h0 = 0;
    h1 = 0;
    h2 = 0;
    repeat (50) begin
      @(posedge ref_clk);
      h0 += hi[0];
      h1 += hi[1];
      h2 += hi[2];
    end
    check(32'(h0), 32'd20);
    check(32'(h1), 32'd0);
    check(32'(h2), 32'd50);
    check({24'h0, faults}, 32'h0);
    // Stopping keeps the count where it was
    setup(2'h0, 2'h0, 4'h0, 15'h0064);
    repeat (37) @(posedge ref_clk);
    wr(`OFS_CTRL, 32'h0);
    rdr(`OFS_COUNT);
    c = rd;
    check({31'h0, c[14:0] != 15'h0}, 32'h1);
    repeat (10) @(posedge ref_clk);
    rdr(`OFS_COUNT);
    check(rd, c);
    // Direction flag differs between the match and the zero event
    setup(2'h3, 2'h3, 4'h0, 15'h2);
    @(posedge ref_clk iff tb_event === 1'b1);
    rdr(`OFS_COUNT);
    d0 = rd[15];
    @(posedge ref_clk iff tb_event === 1'b1);
    rdr(`OFS_COUNT);
    check({31'h0, rd[15] ^ d0}, 32'h1);
    // Reset in mid-run: pins and registers back to idle
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check({26'h0, hi, lo}, 32'h7);
    rdr(`OFS_CTRL);
    check(rd, 32'h0);
    rdr(`OFS_COUNT);
    check(rd, 32'h0);
    complete_run();
  end
endmodule : motor_pwm_time_base_edge_tb
